/* File: pew_pkg.sv */
`default_nettype none
package pew_pkg;
	// register offsets, byte addresses of each 16-bit register
	localparam logic [7:0] PEW_OFS_CTRL = 8'hd4; // power_event_control
	localparam logic [7:0] PEW_OFS_TIME = 8'hd6; // sleep_wake_timing
	localparam logic [7:0] PEW_OFS_PRST = 8'hd8; // phy_block_reset
	// power_event_control, sleep_wake_timing and phy_block_reset field positions
	localparam int PEW_B_DLY = 14; // output delay enable
	localparam int PEW_B_RSV = 13; // reserved, read/write
	localparam int PEW_B_POL = 12; // output polarity
	localparam int PEW_B_EN = 8; // event enables, bits 11..8
	localparam int PEW_B_AUTO = 7; // automatic wake-up enable
	localparam int PEW_B_TONRM = 6; // wake to normal mode
	localparam int PEW_B_STS = 2; // wake status, bits 5..2
	localparam int PEW_B_MODE = 0; // mode, bits 1..0
	localparam int PEW_B_WAKET = 8; // wake-up time, bits 15..8
	localparam int PEW_B_SLEEPT = 0; // go-sleep time, bits 7..0
	localparam int PEW_B_PRST = 0; // phy reset strobe
	// event bit order inside enable and status fields
	localparam int PEW_EV_ENERGY = 0;
	localparam int PEW_EV_LINK = 1;
	localparam int PEW_EV_MAGIC = 2;
	localparam int PEW_EV_FRAME = 3;
	// values after reset
	localparam logic [7:0] PEW_RST_WAKET = 8'h08;
	localparam logic [7:0] PEW_RST_SLEEPT = 8'h0c;
	localparam logic [3:0] PEW_RST_STS = 4'h0;
	// time units and derived cycle counts at 100 MHz
	localparam longint PEW_CLK_HZ = 100000000;
	localparam longint PEW_WAKE_UNIT_MS = 16;
	localparam longint PEW_SLEEP_UNIT_S = 1;
	localparam int PEW_CYC_WAKE_UNIT = int'(PEW_CLK_HZ * PEW_WAKE_UNIT_MS / 1000);
	localparam int PEW_CYC_SLEEP_UNIT = int'(PEW_CLK_HZ * PEW_SLEEP_UNIT_S);
	// power management modes
	typedef enum logic [1:0] {
		PEW_MODE_NORMAL = 2'b00,
		PEW_MODE_EDETECT = 2'b01,
		PEW_MODE_RSVD = 2'b10,
		PEW_MODE_SAVING = 2'b11
	} pew_mode_e;
	// power state inside energy-detect mode
	typedef enum logic [0:0] {
		PEW_PWR_NORMAL = 1'b0,
		PEW_PWR_LOW = 1'b1
	} pew_pwr_e;
	// software control fields of power_event_control
	typedef struct packed {
		logic dlyEn;
		logic rsv;
		logic polHigh;
		logic [3:0] evEn;
		logic autoWake;
		logic toNormal;
		pew_mode_e mode;
	} pew_ctl_s;
	localparam pew_ctl_s PEW_RST_CTL = '{1'b0, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, PEW_MODE_NORMAL};
endpackage
`default_nettype wire

/* File: pew_wake_ctrl.sv */
`default_nettype none
// Notes on behaviour
// - polarity bit 1: pin active high, else low
// - enables bits 11..8: frame, magic, link, energy
// - enabled events assert pin, disabled ones don't
// - auto wake leaves low power after sustained energy
// - wake-to-normal clears mode, needs auto wake
// - status one bit per event: energy, link, magic, frame
// - energy and link events also pulse interrupt bits
// - status cleared by power-up reset or write-one
// - cleared status releases the power event pin
// - mode 00 normal, 01 detect, 11 saving
// - host access or energy wakes low power state
// - wake needs energy for field times 16 ms
// - sleep needs no energy for field times 1 s
// - phy reset bit is write-only, self clearing
// - delay enable holds pin until clocks ready, only while auto wake is also set
module pew_wake_ctrl
	import pew_pkg::*;
#(
	parameter int CYC_WAKE_UNIT = PEW_CYC_WAKE_UNIT, // cycles per 16 ms unit
	parameter int CYC_SLEEP_UNIT = PEW_CYC_SLEEP_UNIT // cycles per 1 s unit
) (
	input wire logic clk, // 100 MHz clock
	input wire logic rst, // hardware reset, sync, high
	input wire logic porRst, // power-up reset, sync, high
	input wire logic [7:0] regAddr, // register byte address
	input wire logic [1:0] regBe, // byte enables
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	input wire logic [15:0] regWdata, // write data
	output logic [15:0] regRdata, // read data, one cycle after strobe
	input wire logic evEnergy, // energy wake event pulse
	input wire logic evLinkUp, // link down-to-up pulse
	input wire logic evMagic, // magic packet pulse
	input wire logic evFrame, // wake-up frame pulse
	input wire logic energyPresent, // line energy level
	input wire logic clocksReady, // all clocks run, host ready
	output logic powerEventOut, // power event pin
	output logic lowPower, // energy-detect low power state
	output logic intEnergySet, // sets interrupt status bit 2
	output logic intLinkSet, // sets interrupt status bit 3
	output logic phyReset // one-cycle phy reset pulse
);
	// control, status and timing registers
	pew_ctl_s ctl_ff, nxt_ctl;
	logic [3:0] sts_ff, nxt_sts; // wake status, survives rst
	logic [7:0] wakeT_ff, nxt_wakeT; // wake time in 16 ms units
	logic [7:0] sleepT_ff, nxt_sleepT; // sleep time in 1 s units
	logic [14:0] prstRsv_ff, nxt_prstRsv; // reserved bits of reset register
	logic [15:0] rdata_ff, nxt_rdata;
	logic phyRst_ff, nxt_phyRst;
	// power state and timers
	pew_pwr_e pwr_ff, nxt_pwr;
	logic [26:0] pre_ff, nxt_pre; // prescaler inside one time unit
	logic [7:0] units_ff, nxt_units; // completed units
	logic pme_ff, nxt_pme;
	logic intE_ff, nxt_intE, intL_ff, nxt_intL;
	logic hostAccess; // any register read or write
	logic [3:0] evIn; // raw events in status order
	logic energyWake; // timed energy wake-up fires
	logic pending; // latched enabled event exists
	logic wrCtl, wrTime, wrPrst;

	assign hostAccess = regWr | regRd;
	assign evIn = {evFrame, evMagic, evLinkUp, evEnergy};
	assign wrCtl = regWr && regAddr == PEW_OFS_CTRL;
	assign wrTime = regWr && regAddr == PEW_OFS_TIME;
	assign wrPrst = regWr && regAddr == PEW_OFS_PRST;

	// timers: low state counts energy, normal state counts silence
	always_comb begin
		logic measuring;
		logic [26:0] unitLen;
		logic [7:0] target;
		measuring = 1'b0;
		unitLen = 27'(CYC_WAKE_UNIT);
		target = wakeT_ff;
		nxt_pre = pre_ff;
		nxt_units = units_ff;
		nxt_pwr = pwr_ff;
		energyWake = 1'b0;
		if (pwr_ff == PEW_PWR_LOW) begin
			measuring = energyPresent;
		end else begin
			measuring = !energyPresent && ctl_ff.mode == PEW_MODE_EDETECT;
			unitLen = 27'(CYC_SLEEP_UNIT);
			target = sleepT_ff;
		end
		if (!measuring) begin
			// a break restarts the whole period, partial units are lost
			nxt_pre = '0;
			nxt_units = '0;
		end else if (units_ff < target) begin
			if (pre_ff == unitLen - 27'd1) begin
				nxt_pre = '0;
				nxt_units = units_ff + 8'd1;
			end else begin
				nxt_pre = pre_ff + 27'd1;
			end
		end
		// state moves; a zero time field would act at once
		case (pwr_ff)
			PEW_PWR_NORMAL: begin
				if (measuring && units_ff >= target) begin
					nxt_pwr = PEW_PWR_LOW;
				end
			end
			PEW_PWR_LOW: begin
				if (ctl_ff.mode != PEW_MODE_EDETECT || hostAccess) begin
					nxt_pwr = PEW_PWR_NORMAL;
				end else if (ctl_ff.autoWake && measuring && units_ff >= target) begin
					nxt_pwr = PEW_PWR_NORMAL;
					energyWake = 1'b1;
				end
			end
			default: nxt_pwr = PEW_PWR_NORMAL;
		endcase
		if (nxt_pwr != pwr_ff) begin
			nxt_pre = '0;
			nxt_units = '0;
		end
	end

	// register writes, status latching and read data
	always_comb begin
		logic [3:0] setEv;
		nxt_ctl = ctl_ff;
		nxt_wakeT = wakeT_ff;
		nxt_sleepT = sleepT_ff;
		nxt_prstRsv = prstRsv_ff;
		nxt_phyRst = 1'b0;
		nxt_rdata = 16'h0000; // unmapped reads return zero
		setEv = evIn;
		setEv[PEW_EV_ENERGY] = evIn[PEW_EV_ENERGY] | energyWake;
		nxt_sts = sts_ff;
		if (wrCtl) begin
			if (regBe[1]) begin
				nxt_ctl.dlyEn = regWdata[PEW_B_DLY];
				nxt_ctl.rsv = regWdata[PEW_B_RSV];
				nxt_ctl.polHigh = regWdata[PEW_B_POL];
				nxt_ctl.evEn = regWdata[PEW_B_EN +: 4];
			end
			if (regBe[0]) begin
				nxt_ctl.autoWake = regWdata[PEW_B_AUTO];
				nxt_ctl.toNormal = regWdata[PEW_B_TONRM];
				// the reserved code is refused, old mode stays
				if (regWdata[PEW_B_MODE +: 2] != PEW_MODE_RSVD) begin
					nxt_ctl.mode = pew_mode_e'(regWdata[PEW_B_MODE +: 2]);
				end
				nxt_sts = sts_ff & ~regWdata[PEW_B_STS +: 4];
			end
		end
		nxt_sts = nxt_sts | setEv;
		// sustained energy may hand the device back to normal mode
		if (energyWake && ctl_ff.toNormal) begin
			nxt_ctl.mode = PEW_MODE_NORMAL;
		end
		if (wrTime) begin
			if (regBe[1]) begin
				nxt_wakeT = regWdata[PEW_B_WAKET +: 8];
			end
			if (regBe[0]) begin
				nxt_sleepT = regWdata[PEW_B_SLEEPT +: 8];
			end
		end
		if (wrPrst) begin
			if (regBe[0]) begin
				nxt_phyRst = regWdata[PEW_B_PRST];
				nxt_prstRsv[6:0] = regWdata[7:1];
			end
			if (regBe[1]) begin
				nxt_prstRsv[14:7] = regWdata[15:8];
			end
		end
		if (regRd) begin
			case (regAddr)
				PEW_OFS_CTRL: nxt_rdata = {1'b0, ctl_ff.dlyEn, ctl_ff.rsv, ctl_ff.polHigh,
					ctl_ff.evEn, ctl_ff.autoWake, ctl_ff.toNormal, sts_ff, ctl_ff.mode};
				PEW_OFS_TIME: nxt_rdata = {wakeT_ff, sleepT_ff};
				PEW_OFS_PRST: nxt_rdata = {prstRsv_ff, 1'b0}; // strobe reads zero
				default: nxt_rdata = 16'h0000;
			endcase
		end
	end

	// pin and interrupt side effects
	always_comb begin
		logic holdOff;
		pending = |(sts_ff & ctl_ff.evEn);
		holdOff = ctl_ff.dlyEn && ctl_ff.autoWake && !clocksReady;
		// polarity applied last so an idle pin sits at its inactive level
		nxt_pme = (pending && !holdOff) ? ctl_ff.polHigh : !ctl_ff.polHigh;
		nxt_intE = evIn[PEW_EV_ENERGY] | energyWake;
		nxt_intL = evIn[PEW_EV_LINK];
	end

	// registers; wake status only listens to power-up reset
	always_ff @(posedge clk) begin
		if (porRst) begin
			sts_ff <= PEW_RST_STS;
		end else begin
			sts_ff <= nxt_sts;
		end
		if (rst || porRst) begin
			ctl_ff <= PEW_RST_CTL;
			wakeT_ff <= PEW_RST_WAKET;
			sleepT_ff <= PEW_RST_SLEEPT;
			prstRsv_ff <= '0;
			rdata_ff <= '0;
			phyRst_ff <= 1'b0;
			pwr_ff <= PEW_PWR_NORMAL;
			pre_ff <= '0;
			units_ff <= '0;
			pme_ff <= 1'b1; // inactive for the reset polarity of zero
			intE_ff <= 1'b0;
			intL_ff <= 1'b0;
		end else begin
			ctl_ff <= nxt_ctl;
			wakeT_ff <= nxt_wakeT;
			sleepT_ff <= nxt_sleepT;
			prstRsv_ff <= nxt_prstRsv;
			rdata_ff <= nxt_rdata;
			phyRst_ff <= nxt_phyRst;
			pwr_ff <= nxt_pwr;
			pre_ff <= nxt_pre;
			units_ff <= nxt_units;
			pme_ff <= nxt_pme;
			intE_ff <= nxt_intE;
			intL_ff <= nxt_intL;
		end
	end

	assign regRdata = rdata_ff;
	assign powerEventOut = pme_ff;
	assign lowPower = pwr_ff; // low state is encoded as one, so no gate on the pin
	assign intEnergySet = intE_ff;
	assign intLinkSet = intL_ff;
	assign phyReset = phyRst_ff;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || porRst);

	sequence s_clearAll;
		wrCtl && regBe[0] && (regWdata[5:2] == 4'hf) && (evIn == 4'h0) && !energyWake;
	endsequence

	a_pin_polarity: assert property ($past(pending) && !$past(ctl_ff.dlyEn) |->
		powerEventOut == $past(ctl_ff.polHigh)) else $error("pin level wrong");
	a_event_latch: assert property (evMagic |=> sts_ff[PEW_EV_MAGIC])
		else $error("magic event not latched");
	a_enable_gate: assert property ((ctl_ff.evEn == 4'h0) && $stable(ctl_ff) |=>
		powerEventOut == !$past(ctl_ff.polHigh)) else $error("disabled event drove pin");
	a_clear_release: assert property (s_clearAll ##1 (ctl_ff.dlyEn == 1'b0) |=>
		powerEventOut == !$past(ctl_ff.polHigh)) else $error("pin not released");
	a_w1c_clear: assert property (s_clearAll |=> sts_ff == 4'h0)
		else $error("status not cleared");
	a_phy_pulse: assert property (phyReset |=> !phyReset || $past(wrPrst))
		else $error("phy reset stuck");
	a_int_energy: assert property (evEnergy |=> intEnergySet ##0 sts_ff[0])
		else $error("energy interrupt missing");
	a_mode_rsvd: assert property (ctl_ff.mode != PEW_MODE_RSVD)
		else $error("reserved mode stored");
	a_host_wake: assert property (lowPower && hostAccess |=> !lowPower)
		else $error("host access did not wake");
	a_no_auto: assert property (lowPower && !ctl_ff.autoWake && !hostAccess &&
		ctl_ff.mode == PEW_MODE_EDETECT && $stable(ctl_ff) |=> lowPower)
		else $error("woke without auto wake");
	a_delay_hold: assert property (ctl_ff.dlyEn && ctl_ff.autoWake && !clocksReady |=>
		powerEventOut == !$past(ctl_ff.polHigh)) else $error("pin not held off");
	a_timer_reset: assert property (lowPower && !energyPresent && !hostAccess |=>
		units_ff == 8'd0) else $error("timer not restarted");
	a_to_normal: assert property (energyWake && ctl_ff.toNormal |=>
		ctl_ff.mode == PEW_MODE_NORMAL) else $error("mode not returned");

	// timed moves of the power state must have waited out the period
	sequence s_enterLow;
		!lowPower ##1 lowPower;
	endsequence
	sequence s_leaveLow;
		lowPower ##1 !lowPower;
	endsequence

	a_pin_idle: assert property (!$past(pending) |->
		powerEventOut == !$past(ctl_ff.polHigh)) else $error("pin active without event");
	a_link_int: assert property (evLinkUp |=> intLinkSet ##0 sts_ff[PEW_EV_LINK])
		else $error("link interrupt missing");
	a_int_source: assert property (intEnergySet |->
		$past(evEnergy) || $past(energyWake)) else $error("stray energy interrupt");
	a_phy_write: assert property (wrPrst && regBe[0] && regWdata[PEW_B_PRST] |=>
		phyReset) else $error("phy reset not pulsed");
	a_strobe_read: assert property (regRd && regAddr == PEW_OFS_PRST |=>
		!regRdata[PEW_B_PRST]) else $error("reset strobe read back");
	a_sleep_time: assert property (s_enterLow |->
		$past(units_ff) >= $past(sleepT_ff)) else $error("slept too early");
	a_wake_time: assert property (s_leaveLow |-> $past(hostAccess) ||
		$past(ctl_ff.mode) != PEW_MODE_EDETECT ||
		($past(ctl_ff.autoWake) && $past(units_ff) >= $past(wakeT_ff)))
		else $error("woke too early");
endmodule
`default_nettype wire

/* File: pew_host_model.sv */
`default_nettype none
// host side of the register port: one strobe per access, fields held until taken
module pew_host_model
	import pew_pkg::*;
(
	input wire logic clk, // bench clock
	output var logic [7:0] regAddr, // byte address
	output var logic [1:0] regBe, // byte enables
	output var logic regWr, // write strobe
	output var logic regRd, // read strobe
	output var logic [15:0] regWdata, // write data
	input wire logic [15:0] regRdata // read data
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus from time zero
	initial begin
		regAddr = 8'h00;
		regBe = 2'h3;
		regWr = 1'b0;
		regRd = 1'b0;
		regWdata = 16'h0000;
	end
	// word write; a zero time field is bumped to one, the block must never see it
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] v;
		v = d;
		if (a == PEW_OFS_TIME && v[15:8] == 8'h00) v[15:8] = 8'h01;
		if (a == PEW_OFS_TIME && v[7:0] == 8'h00) v[7:0] = 8'h01;
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// word read; data stands one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [15:0] q);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		q = regRdata;
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top
	import pew_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0; // 100 MHz
	logic rst = 1'b1; // hardware reset
	logic porRst = 1'b1; // power-up reset
	logic [3:0] evs = 4'h0; // event pulses, bit order of status
	logic energyPresent = 1'b1; // line energy
	logic clocksReady = 1'b1; // clocks running
	logic [7:0] regAddr; // host bus
	logic [1:0] regBe;
	logic regWr;
	logic regRd;
	logic [15:0] regWdata;
	logic [15:0] regRdata;
	logic powerEventOut; // pin
	logic lowPower;
	logic intEnergySet;
	logic intLinkSet;
	logic phyReset;
	int nMismatch = 0; // failed compares
	int cmpCount = 0; // all compares
	int nE = 0; // energy interrupt pulses
	int nL = 0; // link interrupt pulses
	int nP = 0; // phy reset pulses
	// clock
	initial begin
		forever #5 clk = ~clk;
	end
	pew_host_model host (.clk(clk), .regAddr(regAddr), .regBe(regBe), .regWr(regWr),
		.regRd(regRd), .regWdata(regWdata), .regRdata(regRdata));
	// short time units keep the sleep and wake waits to tens of cycles
	pew_wake_ctrl #(.CYC_WAKE_UNIT(4), .CYC_SLEEP_UNIT(8)) DUT (.clk(clk), .rst(rst),
		.porRst(porRst), .regAddr(regAddr), .regBe(regBe), .regWr(regWr), .regRd(regRd),
		.regWdata(regWdata), .regRdata(regRdata), .evEnergy(evs[PEW_EV_ENERGY]),
		.evLinkUp(evs[PEW_EV_LINK]), .evMagic(evs[PEW_EV_MAGIC]), .evFrame(evs[PEW_EV_FRAME]),
		.energyPresent(energyPresent), .clocksReady(clocksReady),
		.powerEventOut(powerEventOut), .lowPower(lowPower), .intEnergySet(intEnergySet),
		.intLinkSet(intLinkSet), .phyReset(phyReset));
	// pulse counters, so a stretched or missing pulse shows up
	always @(posedge clk) begin
		nE <= nE + int'(intEnergySet === 1'b1);
		nL <= nL + int'(intLinkSet === 1'b1);
		nP <= nP + int'(phyReset === 1'b1);
	end
	// 16-bit shift register for repeatable stimulus
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// control word image as read back
	function automatic logic [15:0] ctl(input logic dly, input logic pol, input logic [3:0] en,
		input logic au, input logic tn, input logic [3:0] sts, input logic [1:0] md);
		return {1'b0, dly, 1'b0, pol, en, au, tn, sts, md};
	endfunction
	// pin level for an active or idle output
	function automatic logic pinExp(input logic act, input logic pol);
		return act ? pol : ~pol;
	endfunction
	task automatic printVerdict();
		$display("mismatches %0d comparisons %0d", nMismatch, cmpCount);
		if (nMismatch == 0 && cmpCount > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// register value compare
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		cmpCount++;
		if (got !== exp) begin
			nMismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// pin compare
	task automatic chkBit(input logic got, input logic exp, input string m);
		chk({15'h0000, got}, {15'h0000, exp}, m);
	endtask
	// wait n edges, then settle past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// bounded wait for the power state; running out ends the run
	task automatic waitLow(input logic v, input int n);
		for (int i = 0; i < n && lowPower !== v; i++) cyc(1);
		chkBit(lowPower, v, "power state");
		if (lowPower !== v) printVerdict();
	endtask
	initial begin
		logic [15:0] q;
		logic [15:0] seed;
		logic [15:0] c;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		porRst <= 1'b0;
		host.rd(PEW_OFS_CTRL, q);
		chk(q, 16'h0000, "ctrl reset");
		host.rd(PEW_OFS_TIME, q);
		chk(q, {PEW_RST_WAKET, PEW_RST_SLEEPT}, "timing reset");
		host.rd(8'hda, q);
		chk(q, 16'h0000, "unmapped");
		chkBit(powerEventOut, 1'b1, "idle pin");
		// random enables and polarity over every event kind
		seed = 16'd59481;
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			c = ctl(1'b0, seed[0], seed[4:1], 1'b0, 1'b0, 4'h0, 2'b00);
			host.wr(PEW_OFS_CTRL, c);
			@(posedge clk);
			evs <= 4'h1 << (k % 4);
			@(posedge clk);
			evs <= 4'h0;
			cyc(3);
			chkBit(powerEventOut, pinExp(seed[1 + k % 4], seed[0]), "event pin");
			host.rd(PEW_OFS_CTRL, q);
			chk(q, c | (16'h0004 << (k % 4)), "event status");
			host.wr(PEW_OFS_CTRL, c | 16'h003c);
			cyc(3);
			chkBit(powerEventOut, pinExp(1'b0, seed[0]), "released pin");
		end
		chk(16'(nE), 16'd2, "energy int");
		chk(16'(nL), 16'd2, "link int");
		// hardware reset keeps status, power-up reset clears it
		@(posedge clk);
		evs <= 4'h8;
		@(posedge clk);
		evs <= 4'h0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		host.rd(PEW_OFS_CTRL, q);
		chk(q, 16'h0020, "status kept");
		@(posedge clk);
		porRst <= 1'b1;
		repeat (2) @(posedge clk);
		porRst <= 1'b0;
		host.rd(PEW_OFS_CTRL, q);
		chk(q, 16'h0000, "status cleared");
		host.wr(PEW_OFS_PRST, 16'ha5a5);
		cyc(2);
		chk(16'(nP), 16'd1, "phy pulse");
		host.rd(PEW_OFS_PRST, q);
		chkBit(q[0], 1'b0, "phy bit");
		chk(q, 16'ha5a4, "reserved bits");
		host.wr(PEW_OFS_CTRL, 16'h0003);
		host.wr(PEW_OFS_CTRL, 16'h0002);
		host.rd(PEW_OFS_CTRL, q);
		chk(q, 16'h0003, "mode refused");
		// wake 8 cycles, sleep 24 cycles
		host.wr(PEW_OFS_TIME, 16'h0203);
		host.wr(PEW_OFS_CTRL, ctl(1'b0, 1'b1, 4'h1, 1'b1, 1'b1, 4'h0, 2'b01));
		@(posedge clk);
		energyPresent <= 1'b0;
		cyc(18);
		chkBit(lowPower, 1'b0, "early sleep");
		waitLow(1'b1, 20);
		// interrupted energy must not add up
		@(posedge clk);
		energyPresent <= 1'b1;
		repeat (6) @(posedge clk);
		energyPresent <= 1'b0;
		@(posedge clk);
		energyPresent <= 1'b1;
		cyc(6);
		chkBit(lowPower, 1'b1, "broken energy");
		waitLow(1'b0, 10);
		host.rd(PEW_OFS_CTRL, q);
		chk(q, ctl(1'b0, 1'b1, 4'h1, 1'b1, 1'b1, 4'h1, 2'b00), "auto wake");
		chkBit(powerEventOut, 1'b1, "wake pin");
		chk(16'(nE), 16'd3, "wake int");
		// no auto wake; only a host access brings it back
		host.wr(PEW_OFS_CTRL, ctl(1'b0, 1'b1, 4'h0, 1'b0, 1'b0, 4'hf, 2'b01));
		@(posedge clk);
		energyPresent <= 1'b0;
		waitLow(1'b1, 40);
		@(posedge clk);
		energyPresent <= 1'b1;
		cyc(20);
		chkBit(lowPower, 1'b1, "no auto wake");
		host.rd(PEW_OFS_TIME, q);
		cyc(1);
		chkBit(lowPower, 1'b0, "host wake");
		// delayed pin until clocks are ready
		host.wr(PEW_OFS_CTRL, ctl(1'b1, 1'b1, 4'h4, 1'b1, 1'b0, 4'h0, 2'b00));
		@(posedge clk);
		clocksReady <= 1'b0;
		evs <= 4'h4;
		@(posedge clk);
		evs <= 4'h0;
		cyc(4);
		chkBit(powerEventOut, 1'b0, "held pin");
		@(posedge clk);
		clocksReady <= 1'b1;
		cyc(3);
		chkBit(powerEventOut, 1'b1, "late pin");
		printVerdict();
	end
endmodule
`default_nettype wire
